// ### verilog/pwu_output_stage.sv
/*
 * pwu_output_stage: 16-bit pwm unit with one compare module, shadowed
 * period and duty, output selector for the shared pin, interrupt flags,
 * and a classic wishbone register slave.
 * assumes one clock, synchronous active-high reset, an external clocking
 * signal from outside the clock domain, and the port latch of the pin's
 * general i/o path on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pwu_output_stage (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire pwu_pkg::pwu_wb_req_t wb_req_i,
    output pwu_pkg::pwu_wb_rsp_t wb_rsp_o,
    input wire logic ext_clk_i,
    input wire logic gpio_dout_i,
    input wire logic gpio_oe_n_i,
    output logic pin_o,
    output logic pin_oe_n_o,
    output logic irq_o
);

    function automatic logic reg_hit(input logic [31:0] adr, input logic [7:0] idx);
        reg_hit = (adr == {22'h0, idx, 2'b00});
    endfunction : reg_hit

    // software registers
    logic [15:0] duty;
    logic [15:0] period;
    logic [7:0] ctrl;
    logic [7:0] ic;
    logic [7:0] evt;
    logic [7:0] evt_mask;
    // datapath state
    logic [15:0] sh_duty;
    logic [15:0] sh_period;
    logic [15:0] count;
    logic [1:0] ext_sync;
    logic ack;
    logic [31:0] rdat;
    logic pin;
    logic pin_oe_n;

    // bus decode
    wire acc = wb_req_i.cyc & wb_req_i.stb & ~ack;
    wire wr = acc & wb_req_i.we & wb_req_i.sel[0];
    wire rd = acc & ~wb_req_i.we;
    wire [7:0] wdat = wb_req_i.dat[7:0];
    wire hit_duty_h = reg_hit(wb_req_i.adr, pwu_pkg::IDX_DUTY_HIGH);
    wire hit_duty_l = reg_hit(wb_req_i.adr, pwu_pkg::IDX_DUTY_LOW);
    wire hit_per_h = reg_hit(wb_req_i.adr, pwu_pkg::IDX_PERIOD_HIGH);
    wire hit_per_l = reg_hit(wb_req_i.adr, pwu_pkg::IDX_PERIOD_LOW);
    wire hit_cnt_h = reg_hit(wb_req_i.adr, pwu_pkg::IDX_COUNT_HIGH);
    wire hit_cnt_l = reg_hit(wb_req_i.adr, pwu_pkg::IDX_COUNT_LOW);
    wire hit_ic = reg_hit(wb_req_i.adr, pwu_pkg::IDX_IRQ_CTRL);
    wire hit_ctl = reg_hit(wb_req_i.adr, pwu_pkg::IDX_UNIT_CTRL);
    wire hit_evt = reg_hit(wb_req_i.adr, pwu_pkg::IDX_EVT_STATUS);
    wire hit_msk = reg_hit(wb_req_i.adr, pwu_pkg::IDX_EVT_MASK);
    wire wr_ctl = wr & hit_ctl;
    wire wr_ic = wr & hit_ic;
    wire rd_evt = rd & hit_evt;

    // control fields
    wire run = ctrl[pwu_pkg::CTL_RUN];
    wire upd_req = ctrl[pwu_pkg::CTL_UPDATE];
    wire oclk_sel = ctrl[pwu_pkg::CTL_OCLK];
    wire start_lvl = ctrl[pwu_pkg::CTL_INV];
    wire out_en = ctrl[pwu_pkg::CTL_EN];
    wire ext_clk_s = ext_sync[1];

    // counter events; all-ones also rolls over so a period of ffffh works
    wire ovt_evt = run & ((count > sh_period) | (&count));
    wire match_evt = run & (count == sh_duty);
    wire reload = ovt_evt & upd_req;
    wire shadow_load = ~run | reload;

    wire [15:0] next_count = ovt_evt ? 16'h0000 : (run ? count + 16'h0001 : count);
    wire [15:0] next_duty = {hit_duty_h & wr ? wdat : duty[15:8],
                             hit_duty_l & wr ? wdat : duty[7:0]};
    // single period pair; more modules would all compare against it
    wire [15:0] next_period = {hit_per_h & wr ? wdat : period[15:8],
                               hit_per_l & wr ? wdat : period[7:0]};
    wire [15:0] next_sh_duty = shadow_load ? duty : sh_duty;
    wire [15:0] next_sh_period = shadow_load ? period : sh_period;

    // a software write of the update bit beats the hardware clear
    wire [7:0] ctl_hw = reload ? {1'b0, ctrl[6:0]} : ctrl;
    wire [7:0] next_ctrl = wr_ctl ? (wdat & pwu_pkg::CTL_WRITABLE) : ctl_hw;

    // hardware set wins over a software clear in the same cycle
    wire [7:0] evt_hw = {ovt_evt, 2'b00, match_evt, 4'h0};
    wire [7:0] ic_base = wr_ic ? (wdat & pwu_pkg::IC_WRITABLE) : ic;
    wire [7:0] next_ic = ic_base | evt_hw;
    wire [7:0] next_evt = (rd_evt ? pwu_pkg::RST_EVT : evt) | evt_hw;
    wire [7:0] next_evt_mask = wr & hit_msk ? (wdat & pwu_pkg::EVT_WRITABLE) : evt_mask;

    // output waveform
    wire pwm_lvl = (count < sh_duty) ? start_lvl : ~start_lvl;
    wire next_pin = out_en ? (oclk_sel ? ext_clk_s : pwm_lvl) : gpio_dout_i;
    wire next_pin_oe_n = out_en ? 1'b0 : gpio_oe_n_i;

    // read mux; unmapped words read zero
    wire [7:0] rd_byte =
        hit_duty_h ? duty[15:8] :
        hit_duty_l ? duty[7:0] :
        hit_per_h ? period[15:8] :
        hit_per_l ? period[7:0] :
        hit_cnt_h ? count[15:8] :
        hit_cnt_l ? count[7:0] :
        hit_ic ? ic :
        hit_ctl ? ctrl :
        hit_evt ? evt :
        hit_msk ? evt_mask : 8'h00;

    wire irq_flags = (ic[pwu_pkg::IC_OVT_FLAG] & ic[pwu_pkg::IC_OVT_EN])
                   | (ic[pwu_pkg::IC_MATCH_FLAG] & ic[pwu_pkg::IC_MATCH_EN]);

    always_ff @(posedge clk_i)
    begin
        ext_sync <= {ext_sync[0], ext_clk_i};
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            duty <= pwu_pkg::RST_DUTY;
            period <= pwu_pkg::RST_PERIOD;
            ctrl <= pwu_pkg::RST_CTRL;
            ic <= pwu_pkg::RST_IC;
            evt <= pwu_pkg::RST_EVT;
            evt_mask <= pwu_pkg::RST_EVT_MASK;
        end
        else
        begin
            duty <= next_duty;
            period <= next_period;
            ctrl <= next_ctrl;
            ic <= next_ic;
            evt <= next_evt;
            evt_mask <= next_evt_mask;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sh_duty <= pwu_pkg::RST_DUTY;
            sh_period <= pwu_pkg::RST_PERIOD;
            count <= pwu_pkg::RST_COUNT;
        end
        else
        begin
            sh_duty <= next_sh_duty;
            sh_period <= next_sh_period;
            count <= next_count;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin <= 1'b0;
            pin_oe_n <= 1'b1;
        end
        else
        begin
            pin <= next_pin;
            pin_oe_n <= next_pin_oe_n;
        end
    end

    // one wait state: ack registered, dropped the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack <= 1'b0;
            rdat <= 32'h00000000;
        end
        else
        begin
            ack <= acc;
            rdat <= acc ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    assign wb_rsp_o = '{ack: ack, dat: rdat};
    assign pin_o = pin;
    assign pin_oe_n_o = pin_oe_n;
    // read-clear status is separate so reading never loses documented flags
    assign irq_o = irq_flags | (|(evt & evt_mask));

    chk_low_level: assert property (
        @(posedge clk_i) disable iff (rst_i)
        out_en & ~oclk_sel & run & (count < sh_duty) |=> pin_o == $past(start_lvl))
        else $error("pin not at start level below duty");

    chk_high_level: assert property (
        @(posedge clk_i) disable iff (rst_i)
        out_en & ~oclk_sel & run & (count >= sh_duty) |=> pin_o != $past(start_lvl))
        else $error("pin not inverted at or above duty");

    chk_counter_reload: assert property (
        @(posedge clk_i) disable iff (rst_i)
        run & (count > sh_period) |=> count == 16'h0000)
        else $error("counter not reloaded after overtaking");

    chk_counter_up: assert property (
        @(posedge clk_i) disable iff (rst_i)
        run & (count < sh_period) |=> count == $past(count) + 16'h0001)
        else $error("counter did not advance by one");

    chk_shadow_reload: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ovt_evt & upd_req |=> (sh_duty == $past(duty)) && (sh_period == $past(period)))
        else $error("shadows not reloaded on overtaking");

    chk_shadow_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        run & ~ovt_evt |=> $stable(sh_duty) && $stable(sh_period))
        else $error("shadow changed while running without reload");

    chk_stopped_copy: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ~run ##1 ~run |-> (sh_duty == $past(duty)) && (sh_period == $past(period)))
        else $error("shadows not following while stopped");

    chk_update_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ovt_evt & upd_req & ~wr_ctl |=> ~ctrl[pwu_pkg::CTL_UPDATE])
        else $error("update request not cleared after load");

    chk_ovt_flag: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ovt_evt |=> ic[pwu_pkg::IC_OVT_FLAG] && evt[pwu_pkg::IC_OVT_FLAG])
        else $error("overtake flag not set");

    chk_match_flag: assert property (
        @(posedge clk_i) disable iff (rst_i)
        match_evt |=> ic[pwu_pkg::IC_MATCH_FLAG])
        else $error("match flag not set");

    chk_flag_sticky: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ic[pwu_pkg::IC_OVT_FLAG] & ~wr_ic |=> ic[pwu_pkg::IC_OVT_FLAG])
        else $error("overtake flag cleared without software");

    chk_irq_flags: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ~(ic[pwu_pkg::IC_OVT_FLAG] & ic[pwu_pkg::IC_OVT_EN]) &
        ~(ic[pwu_pkg::IC_MATCH_FLAG] & ic[pwu_pkg::IC_MATCH_EN]) &
        ((evt & evt_mask) == 8'h00) |-> ~irq_o)
        else $error("interrupt raised with no enabled flag");

    chk_ovt_irq: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ic[pwu_pkg::IC_OVT_FLAG] & ic[pwu_pkg::IC_OVT_EN] |-> irq_o)
        else $error("enabled overtake flag not raising interrupt");

    chk_match_irq: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ic[pwu_pkg::IC_MATCH_FLAG] & ic[pwu_pkg::IC_MATCH_EN] |-> irq_o)
        else $error("enabled match flag not raising interrupt");

    chk_match_sticky: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ic[pwu_pkg::IC_MATCH_FLAG] & ~wr_ic |=> ic[pwu_pkg::IC_MATCH_FLAG])
        else $error("match flag cleared without software");

    chk_unused_bits: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ic & ~pwu_pkg::IC_WRITABLE) == 8'h00)
        else $error("unused interrupt register bits set");

    chk_clock_out: assert property (
        @(posedge clk_i) disable iff (rst_i)
        out_en & oclk_sel |=> pin_o == $past(ext_clk_s) && ~pin_oe_n_o)
        else $error("pin not carrying external clock");

    chk_io_mode: assert property (
        @(posedge clk_i) disable iff (rst_i)
        // release edge still loads the reset values into the pin
        ~rst_i & ~out_en |=> pin_o == $past(gpio_dout_i) && pin_oe_n_o == $past(gpio_oe_n_i))
        else $error("pin not handed to general i/o");

    chk_bus_ack: assert property (
        @(posedge clk_i) disable iff (rst_i)
        acc |=> ack ##1 ~ack)
        else $error("bus ack not a single cycle");

    chk_ack_idle: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ~(wb_req_i.cyc & wb_req_i.stb) |=> ~ack)
        else $error("ack without a request");

    chk_duty_high_write: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr & hit_duty_h |=> duty[15:8] == $past(wdat))
        else $error("duty high byte not written");

    chk_duty_low_write: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr & hit_duty_l |=> duty[7:0] == $past(wdat))
        else $error("duty low byte not written");

    chk_period_write: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr & hit_per_l |=> period[7:0] == $past(wdat))
        else $error("period low byte not written");

    chk_pin_driven: assert property (
        @(posedge clk_i) disable iff (rst_i)
        out_en |=> ~pin_oe_n_o)
        else $error("pin not driven while output enabled");

    chk_update_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd_req & ~ovt_evt & ~wr_ctl |=> upd_req)
        else $error("update request dropped before overtaking");

    chk_shadow_keep: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ovt_evt & ~upd_req |=> $stable(sh_duty) && $stable(sh_period))
        else $error("shadow reloaded without update request");

    chk_stopped_count: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ~run |=> $stable(count))
        else $error("counter moved while stopped");

    chk_ic_readback: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd & hit_ic |=> wb_rsp_o.dat == {24'h000000, $past(ic)})
        else $error("interrupt register read data wrong");

    chk_status_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_evt & ~ovt_evt & ~match_evt |=> evt == 8'h00)
        else $error("event status not cleared by read");

    chk_ctrl_unused: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ctrl & ~pwu_pkg::CTL_WRITABLE) == 8'h00)
        else $error("unused control bits set");

    chk_ctrl_reset: assert property (
        @(posedge clk_i)
        rst_i |=> ctrl == pwu_pkg::RST_CTRL && pin_oe_n_o)
        else $error("control register or pin not reset");

    chk_ic_reset: assert property (
        @(posedge clk_i)
        rst_i |=> ic == pwu_pkg::RST_IC)
        else $error("interrupt register not reset");

    chk_duty_reset: assert property (
        @(posedge clk_i)
        rst_i |=> duty == pwu_pkg::RST_DUTY)
        else $error("duty register not reset");

    chk_period_reset: assert property (
        @(posedge clk_i)
        rst_i |=> period == pwu_pkg::RST_PERIOD && count == pwu_pkg::RST_COUNT)
        else $error("period or counter not reset");

endmodule : pwu_output_stage

`default_nettype wire

// ### verilog/pwu_pkg.sv
/*
 * pwu_pkg: register indices, field positions, reset values and bus carriers
 * for the pwm unit output stage.
 * assumes a classic wishbone master with 32-bit data; registers are 8 bits
 * wide, one per aligned word, byte address = 4 * register index.
 */
`default_nettype none

package pwu_pkg;

    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_DUTY_HIGH = 8'hc9;
    localparam logic [7:0] IDX_DUTY_LOW = 8'hca;
    localparam logic [7:0] IDX_PERIOD_HIGH = 8'hfa;
    localparam logic [7:0] IDX_PERIOD_LOW = 8'hfb;
    localparam logic [7:0] IDX_COUNT_HIGH = 8'hfc;
    localparam logic [7:0] IDX_COUNT_LOW = 8'hfd;
    localparam logic [7:0] IDX_IRQ_CTRL = 8'hfe;
    localparam logic [7:0] IDX_UNIT_CTRL = 8'hf8;
    localparam logic [7:0] IDX_EVT_STATUS = 8'hf7;
    localparam logic [7:0] IDX_EVT_MASK = 8'hf6;

    // unit control register fields
    localparam int CTL_UPDATE = 7;
    localparam int CTL_RUN = 6;
    localparam int CTL_OCLK = 4;
    localparam int CTL_INV = 1;
    localparam int CTL_EN = 0;
    localparam logic [7:0] CTL_WRITABLE = 8'hd3;

    // interrupt flags and enables register fields
    localparam int IC_OVT_FLAG = 7;
    localparam int IC_MATCH_FLAG = 4;
    localparam int IC_OVT_EN = 3;
    localparam int IC_MATCH_EN = 0;
    localparam logic [7:0] IC_WRITABLE = 8'h99;
    localparam logic [7:0] EVT_WRITABLE = 8'h90;

    // reset values
    localparam logic [15:0] RST_DUTY = 16'h0000;
    localparam logic [15:0] RST_PERIOD = 16'hffff;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_IC = 8'h00;
    localparam logic [7:0] RST_EVT = 8'h00;
    localparam logic [7:0] RST_EVT_MASK = 8'h00;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [31:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } pwu_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } pwu_wb_rsp_t;

endpackage : pwu_pkg

`default_nettype wire

// ### sim/pwu_pin_load.sv
/*
 * pwu_pin_load: load on the shared output pin, with a pull-up.
 * assumes the pin's enable is active low and only the unit drives the pin.
 */
`timescale 1ns/1ps
`default_nettype none

module pwu_pin_load (
    input wire logic pin_i,
    input wire logic pin_oe_n_i,
    output logic level_o
);
    // released pin floats up; never shows the last driven value
    assign level_o = pin_oe_n_i ? 1'b1 : pin_i;
endmodule : pwu_pin_load

`default_nettype wire

// ### sim/pwu_output_stage_tb.sv
/*
 * pwu_output_stage_tb: register-level bench for the pwm output stage.
 * assumes the wishbone slave answers within a few cycles and the pin
 * load model pulls the pin high when released.
 */
`timescale 1ns/1ps
`default_nettype none

module pwu_output_stage_tb;
    logic clk_i;
    logic rst_i;
    pwu_pkg::pwu_wb_req_t req;
    pwu_pkg::pwu_wb_rsp_t rsp;
    logic ext_clk_i;
    logic gpio_dout_i;
    logic gpio_oe_n_i;
    logic pin_o;
    logic pin_oe_n_o;
    logic irq_o;
    logic level;
    int fail_count;
    int cmp_count;
    int h;

    pwu_output_stage dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_req_i(req),
        .wb_rsp_o(rsp),
        .ext_clk_i(ext_clk_i),
        .gpio_dout_i(gpio_dout_i),
        .gpio_oe_n_i(gpio_oe_n_i),
        .pin_o(pin_o),
        .pin_oe_n_o(pin_oe_n_o),
        .irq_o(irq_o)
    );

    pwu_pin_load load (
        .pin_i(pin_o),
        .pin_oe_n_i(pin_oe_n_o),
        .level_o(level)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one classic cycle, then one idle cycle before the next request
    task automatic bus(input logic [7:0] idx, input logic we, input logic [7:0] wd,
                       output logic [7:0] rd);
        int n;
        req.cyc <= 1'b1;
        req.stb <= 1'b1;
        req.we <= we;
        req.adr <= {22'h0, idx, 2'b00};
        req.sel <= 4'hf;
        req.dat <= {24'h000000, wd};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (rsp.ack !== 1'b1 && n < 50);
        if (rsp.ack !== 1'b1)
        begin
            fail_count++;
            finish_test();
        end
        else
        begin
            rd = rsp.dat[7:0];
            req.cyc <= 1'b0;
            req.stb <= 1'b0;
            @(posedge clk_i);
        end
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        bus(idx, 1'b1, wd, d);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        bus(idx, 1'b0, 8'h00, d);
        chk(d, exp);
    endtask : rdc

    // 50 cycles is ten whole periods of a five-cycle waveform
    task automatic highs(input logic [7:0] exp);
        h = 0;
        repeat (50)
        begin
            @(posedge clk_i);
            h += (level === 1'b1);
        end
        chk(h[7:0], exp);
    endtask : highs

    initial
    begin
        fail_count = 0;
        cmp_count = 0;
        req = '0;
        rst_i = 1'b1;
        ext_clk_i = 1'b0;
        gpio_dout_i = 1'b1;
        gpio_oe_n_i = 1'b0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(pwu_pkg::IDX_DUTY_HIGH, 8'h00);
        rdc(pwu_pkg::IDX_DUTY_LOW, 8'h00);
        rdc(pwu_pkg::IDX_IRQ_CTRL, 8'h00);
        rdc(pwu_pkg::IDX_UNIT_CTRL, 8'h00);
        rdc(pwu_pkg::IDX_PERIOD_LOW, 8'hff);
        // counter is read-only and idle at zero until run is set
        wr(pwu_pkg::IDX_COUNT_LOW, 8'h5a);
        rdc(pwu_pkg::IDX_COUNT_LOW, 8'h00);
        rdc(pwu_pkg::IDX_COUNT_HIGH, 8'h00);
        wr(8'h00, 8'h5a);
        rdc(8'h00, 8'h00);
        chk({pin_oe_n_o, pin_o}, 8'h01);
        // duty 2, period 3: five-cycle period, two low then three high
        wr(pwu_pkg::IDX_DUTY_LOW, 8'h02);
        wr(pwu_pkg::IDX_PERIOD_HIGH, 8'h00);
        wr(pwu_pkg::IDX_PERIOD_LOW, 8'h03);
        wr(pwu_pkg::IDX_IRQ_CTRL, 8'h09);
        wr(pwu_pkg::IDX_UNIT_CTRL, 8'h41);
        repeat (4) @(posedge clk_i);
        highs(8'd30);
        rdc(pwu_pkg::IDX_IRQ_CTRL, 8'h99);
        chk({7'h00, irq_o}, 8'h01);
        // new duty must wait for an update request
        wr(pwu_pkg::IDX_DUTY_LOW, 8'h04);
        highs(8'd30);
        wr(pwu_pkg::IDX_UNIT_CTRL, 8'hc1);
        repeat (10) @(posedge clk_i);
        rdc(pwu_pkg::IDX_UNIT_CTRL, 8'h41);
        highs(8'd10);
        wr(pwu_pkg::IDX_UNIT_CTRL, 8'h43);
        repeat (4) @(posedge clk_i);
        highs(8'd40);
        // stopped: shadows follow, flags only change by software
        wr(pwu_pkg::IDX_UNIT_CTRL, 8'h01);
        wr(pwu_pkg::IDX_DUTY_LOW, 8'h01);
        wr(pwu_pkg::IDX_IRQ_CTRL, 8'h09);
        rdc(pwu_pkg::IDX_IRQ_CTRL, 8'h09);
        chk({7'h00, irq_o}, 8'h00);
        wr(pwu_pkg::IDX_IRQ_CTRL, 8'h90);
        chk({7'h00, irq_o}, 8'h00);
        wr(pwu_pkg::IDX_IRQ_CTRL, 8'h98);
        chk({7'h00, irq_o}, 8'h01);
        wr(pwu_pkg::IDX_IRQ_CTRL, 8'h11);
        chk({7'h00, irq_o}, 8'h01);
        wr(pwu_pkg::IDX_IRQ_CTRL, 8'hff);
        rdc(pwu_pkg::IDX_IRQ_CTRL, 8'h99);
        wr(pwu_pkg::IDX_IRQ_CTRL, 8'h00);
        // read-clear status kept both events from the running phase
        wr(pwu_pkg::IDX_EVT_MASK, 8'hff);
        rdc(pwu_pkg::IDX_EVT_MASK, 8'h90);
        chk({7'h00, irq_o}, 8'h01);
        rdc(pwu_pkg::IDX_EVT_STATUS, 8'h90);
        chk({7'h00, irq_o}, 8'h00);
        rdc(pwu_pkg::IDX_EVT_STATUS, 8'h00);
        wr(pwu_pkg::IDX_EVT_MASK, 8'h00);
        wr(pwu_pkg::IDX_UNIT_CTRL, 8'h41);
        repeat (4) @(posedge clk_i);
        highs(8'd40);
        // external clock passes to the pin
        wr(pwu_pkg::IDX_UNIT_CTRL, 8'h11);
        ext_clk_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk({pin_oe_n_o, pin_o}, 8'h01);
        ext_clk_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk({pin_oe_n_o, pin_o}, 8'h00);
        // reset with the pin on the external clock: registers and pin return to reset state
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk({pin_oe_n_o, pin_o}, 8'h02);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(pwu_pkg::IDX_UNIT_CTRL, 8'h00);
        rdc(pwu_pkg::IDX_PERIOD_HIGH, 8'hff);
        rdc(pwu_pkg::IDX_DUTY_LOW, 8'h00);
        chk({pin_oe_n_o, pin_o}, 8'h01);
        // back to plain i/o, pin released
        wr(pwu_pkg::IDX_UNIT_CTRL, 8'h00);
        gpio_dout_i <= 1'b0;
        gpio_oe_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({pin_oe_n_o, level}, 8'h03);
        chk({pin_oe_n_o, pin_o}, 8'h02);
        finish_test();
    end
endmodule : pwu_output_stage_tb

`default_nettype wire
